// file: src/drs_sequencer.sv
// Command decode and read data sequencing for a floppy controller core
module drs_sequencer import drs_pkg::*; #(
  parameter int TICK_DIV = TICK_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic cmdValid,
  input wire logic [7:0] cmdByte,
  output logic cmdReady,
  output logic resValid,
  output logic [7:0] resByte,
  input wire logic resAck,
  output logic dataValid,
  output logic [7:0] dataByte,
  input wire logic dataReady,
  input wire logic terminal_count,
  input wire logic impliedSeekEn,
  input wire logic [7:0] settleTicks,
  input wire logic [7:0] unloadTicks,
  output logic seekReq,
  output logic [7:0] seekCyl,
  input wire logic seekDone,
  input wire logic seekOk,
  input wire logic [7:0] seekFailCyl,
  input wire logic index_pulse_input,
  input wire logic idValid,
  input wire drs_id_t idField,
  input wire logic idCrcOk,
  input wire logic markValid,
  input wire logic markDeleted,
  input wire logic diskByteValid,
  input wire logic [7:0] diskByte,
  input wire logic sectorEnd,
  input wire logic dataCrcOk,
  output logic headLoad,
  output logic [3:0] driveBusy,
  output logic standby,
  output logic otherCmd,
  output drs_perp_t perpMode,
  output logic [7:0] dumpCount
);
  if (TICK_DIV < 1) begin : g_chk
    $error("TICK_DIV must be at least one");
  end

  typedef enum logic [3:0] {
    S_IDLE, S_PARAM, S_PERP, S_SEEK, S_LOAD, S_SEARCH, S_MARK, S_DATA, S_RESULT
  } drs_state_t;

  // ---------------------------------------------------------------
  // Tick divider
  // ---------------------------------------------------------------
  logic [31:0] divCnt_q, divCnt_d;
  logic tick_q, tick_d;

  always_comb begin
    tick_d = (divCnt_q == 32'(TICK_DIV - 1));
    divCnt_d = tick_d ? '0 : divCnt_q + 32'h1;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      divCnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      divCnt_q <= divCnt_d;
      tick_q <= tick_d;
    end
  end

  // ---------------------------------------------------------------
  // Sequencer state
  // ---------------------------------------------------------------
  drs_state_t state_q, state_d;
  logic [7:0] cmd_q, cmd_d;
  logic [7:0] par_q [PARAM_BYTES];
  logic [7:0] par_d [PARAM_BYTES];
  logic [2:0] parIdx_q, parIdx_d;
  logic [2:0] resIdx_q, resIdx_d;
  logic oneByteRes_q, oneByteRes_d;
  logic [1:0] ic_q, ic_d;
  logic nd_q, nd_d, de_q, de_d, dd_q, dd_d, cm_q, cm_d;
  logic cmStop_q, cmStop_d, stopSend_q, stopSend_d;
  logic [1:0] idxCnt_q, idxCnt_d;
  logic [14:0] byteCnt_q, byteCnt_d;
  logic [7:0] wait_q, wait_d;
  logic [7:0] curCyl_q, curCyl_d;
  logic headLoad_q, headLoad_d;
  logic seekReq_q, seekReq_d;
  logic [3:0] busy_q, busy_d;
  logic standby_q, standby_d;
  logic otherCmd_q, otherCmd_d;
  logic lastFmt_q, lastFmt_d;
  drs_perp_t perp_q, perp_d;
  logic resValid_q, resValid_d;
  logic [7:0] resByte_q, resByte_d;
  logic cmdReady_q, cmdReady_d;
  logic [7:0] dumpCount_q, dumpCount_d;
  logic fifoInValid, fifoInReady;

  logic [4:0] op;
  logic isXfer, isRead, isDel, mt, sk, deliver, isKnown, lastOnTrack;
  logic [14:0] secLen, xferLen;
  logic [7:0] st0, st1, st2, nextByte;

  // Command classification; the low five bits alone pick the transfer kind
  always_comb begin
    op = cmd_q[4:0];
    isXfer = (op == OP_READ) || (op == OP_READ_DEL) || (op == OP_WRITE)
             || (op == OP_WRITE_DEL) || (op == OP_VERIFY);
    isRead = (op == OP_READ) || (op == OP_READ_DEL);
    isDel = (op == OP_READ_DEL);
    mt = cmd_q[MT_BIT];
    sk = cmd_q[SK_BIT];
    deliver = isRead && !stopSend_q;
    secLen = BASE_SECTOR_BYTES << par_q[P_SIZE][2:0];
    // Short length only applies with size code zero
    if (par_q[P_SIZE][2:0] == 3'h0 && par_q[P_DTL] < 8'h80) begin
      xferLen = {7'h0, par_q[P_DTL]};
    end else begin
      xferLen = secLen;
    end
    lastOnTrack = (par_q[P_SEC] == par_q[P_EOT]) && (!mt || par_q[P_HEAD][0]);
    st0 = {ic_q, 3'h0, par_q[P_SEL][2:0]};
    st1 = 8'h0;
    st1[ST1_ND_BIT] = nd_q;
    st1[ST1_DE_BIT] = de_q;
    st2 = 8'h0;
    st2[ST2_CM_BIT] = cm_q;
    st2[ST2_DD_BIT] = dd_q;
  end

  // Decode of a first command byte against the defined code set
  always_comb begin
    case (cmdByte[4:0])
      5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0a, 5'h0c,
      5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h12, 5'h13, 5'h14, 5'h16: isKnown = 1'b1;
      default: isKnown = 1'b0;
    endcase
  end

  // Result byte selected by the result index
  always_comb begin
    case (resIdx_d)
      3'h0: nextByte = st0;
      3'h1: nextByte = st1;
      3'h2: nextByte = st2;
      3'h3: nextByte = par_q[P_CYL];
      3'h4: nextByte = par_q[P_HEAD];
      3'h5: nextByte = par_q[P_SEC];
      3'h6: nextByte = par_q[P_SIZE];
      default: nextByte = 8'h0;
    endcase
  end

  // Next-state logic for the whole command sequence
  always_comb begin
    state_d = state_q;
    cmd_d = cmd_q;
    par_d = par_q;
    parIdx_d = parIdx_q;
    resIdx_d = resIdx_q;
    oneByteRes_d = oneByteRes_q;
    ic_d = ic_q;
    nd_d = nd_q;
    de_d = de_q;
    dd_d = dd_q;
    cm_d = cm_q;
    cmStop_d = cmStop_q;
    stopSend_d = stopSend_q;
    idxCnt_d = idxCnt_q;
    byteCnt_d = byteCnt_q;
    wait_d = wait_q;
    curCyl_d = curCyl_q;
    headLoad_d = headLoad_q;
    seekReq_d = 1'b0;
    busy_d = busy_q;
    standby_d = standby_q;
    otherCmd_d = 1'b0;
    lastFmt_d = lastFmt_q;
    perp_d = perp_q;
    resValid_d = resValid_q;
    resByte_d = resByte_q;
    fifoInValid = 1'b0;
    case (state_q)
      S_IDLE: begin
        // Head stays loaded until the unload interval runs out
        if (headLoad_q && tick_q) begin
          wait_d = wait_q + 8'h1;
          if (wait_q >= unloadTicks) begin
            headLoad_d = 1'b0;
          end
        end
        if (cmdValid) begin
          cmd_d = cmdByte;
          standby_d = 1'b0;
          if (cmdByte == CMD_PERP) begin
            state_d = S_PERP;
          end else if (!isKnown) begin
            // No-op: standby and a lone status byte
            standby_d = 1'b1;
            oneByteRes_d = 1'b1;
            resIdx_d = 3'h0;
            resByte_d = INVALID_ST0;
            resValid_d = 1'b1;
            state_d = S_RESULT;
          end else if (cmdByte[4:0] == OP_FORMAT) begin
            lastFmt_d = 1'b1;
            otherCmd_d = 1'b1;
          end else if (cmdByte[4:0] inside {OP_READ, OP_READ_DEL, OP_WRITE,
                                            OP_WRITE_DEL, OP_VERIFY}) begin
            lastFmt_d = 1'b0;
            parIdx_d = 3'h0;
            state_d = S_PARAM;
          end else begin
            otherCmd_d = 1'b1;
          end
        end
      end
      S_PERP: begin
        if (cmdValid) begin
          // Drive enables only change when the overwrite bit is set
          perp_d.overwrite = cmdByte[PERP_OW_BIT];
          if (cmdByte[PERP_OW_BIT]) begin
            perp_d.driveEn = cmdByte[5:2];
          end
          perp_d.gapLen = cmdByte[1];
          perp_d.writeGate = cmdByte[0];
          state_d = S_IDLE;
        end
      end
      S_PARAM: begin
        if (cmdValid) begin
          par_d[parIdx_q] = cmdByte;
          parIdx_d = parIdx_q + 3'h1;
          // Execution starts only after the ninth byte
          if (parIdx_q == 3'(PARAM_BYTES - 1)) begin
            {ic_d, nd_d, de_d, dd_d, cm_d, cmStop_d, stopSend_d} = '0;
            idxCnt_d = '0;
            wait_d = '0;
            if (impliedSeekEn && par_d[P_CYL] != curCyl_q) begin
              seekReq_d = 1'b1;
              busy_d[par_d[P_SEL][1:0]] = 1'b1;
              state_d = S_SEEK;
            end else begin
              state_d = S_LOAD;
            end
          end
        end
      end
      S_SEEK: begin
        if (seekDone) begin
          busy_d = '0;
          if (seekOk) begin
            curCyl_d = par_q[P_CYL];
            state_d = S_LOAD;
          end else begin
            ic_d = IC_ABNORMAL;
            par_d[P_CYL] = seekFailCyl;
            curCyl_d = seekFailCyl;
            state_d = S_RESULT;
          end
        end
      end
      S_LOAD: begin
        // A head still loaded from before needs no settling
        if (headLoad_q && wait_q == 8'h0) begin
          state_d = S_SEARCH;
        end else begin
          headLoad_d = 1'b1;
          if (tick_q) begin
            wait_d = wait_q + 8'h1;
          end
          if (wait_q >= settleTicks) begin
            wait_d = '0;
            state_d = S_SEARCH;
          end
        end
      end
      S_SEARCH: begin
        if (index_pulse_input) begin
          idxCnt_d = idxCnt_q + 2'h1;
          if (idxCnt_q == 2'h1) begin
            ic_d = IC_ABNORMAL;
            nd_d = 1'b1;
            state_d = S_RESULT;
          end
        end else if (idValid) begin
          if (!idCrcOk) begin
            ic_d = IC_ABNORMAL;
            de_d = 1'b1;
            dd_d = 1'b1;
            state_d = S_RESULT;
          end else if (idField == {par_q[P_CYL], par_q[P_HEAD], par_q[P_SEC],
                                   par_q[P_SIZE]}) begin
            state_d = S_MARK;
          end
        end
      end
      S_MARK: begin
        if (markValid) begin
          byteCnt_d = '0;
          idxCnt_d = '0;
          if (markDeleted != isDel) begin
            cm_d = 1'b1;
            if (sk) begin
              // Skipped unread: go on to the next sector, or to the result after the last one
              if (lastOnTrack) begin
                state_d = S_RESULT;
              end else begin
                state_d = S_SEARCH;
              end
              if (par_q[P_SEC] == par_q[P_EOT]) begin
                par_d[P_SEC] = FIRST_SECTOR;
                par_d[P_HEAD][0] = ~par_q[P_HEAD][0];
              end else begin
                par_d[P_SEC] = par_q[P_SEC] + 8'h1;
              end
            end else begin
              cmStop_d = 1'b1;
              state_d = S_DATA;
            end
          end else begin
            state_d = S_DATA;
          end
        end
      end
      S_DATA: begin
        if (terminal_count) begin
          stopSend_d = 1'b1;
        end
        if (diskByteValid && byteCnt_q < secLen) begin
          byteCnt_d = byteCnt_q + 15'h1;
          if (deliver && byteCnt_q < xferLen) begin
            fifoInValid = 1'b1;
            // Overrun: FIFO full acts as an implied terminal count
            if (!fifoInReady) begin
              stopSend_d = 1'b1;
            end
          end
        end
        if (sectorEnd) begin
          if (!dataCrcOk) begin
            ic_d = IC_ABNORMAL;
            de_d = 1'b1;
            state_d = S_RESULT;
          end else if (cmStop_q) begin
            state_d = S_RESULT;
          end else begin
            // Advance the address, then stop or read on
            if (par_q[P_SEC] == par_q[P_EOT]) begin
              par_d[P_SEC] = FIRST_SECTOR;
              if (mt) begin
                par_d[P_HEAD][0] = ~par_q[P_HEAD][0];
              end
              if (!mt || par_q[P_HEAD][0]) begin
                par_d[P_CYL] = par_q[P_CYL] + 8'h1;
              end
            end else begin
              par_d[P_SEC] = par_q[P_SEC] + 8'h1;
            end
            if (stopSend_q || terminal_count || lastOnTrack) begin
              state_d = S_RESULT;
            end else begin
              state_d = S_SEARCH;
            end
          end
        end
      end
      S_RESULT: begin
        if (!resValid_q) begin
          oneByteRes_d = 1'b0;
          resIdx_d = 3'h0;
          resByte_d = nextByte;
          resValid_d = 1'b1;
        end else if (resAck) begin
          resIdx_d = resIdx_q + 3'h1;
          resByte_d = nextByte;
          if (oneByteRes_q || resIdx_q == 3'(RESULT_BYTES - 1)) begin
            resValid_d = 1'b0;
            wait_d = '0;
            state_d = S_IDLE;
          end
        end
      end
      default: state_d = S_IDLE;
    endcase
    // Registered so both ports come straight from flops, aligned with the state
    cmdReady_d = (state_d == S_IDLE) || (state_d == S_PARAM) || (state_d == S_PERP);
    dumpCount_d = lastFmt_d ? 8'h0 : par_d[P_EOT];
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q <= S_IDLE;
      cmd_q <= '0;
      for (int i = 0; i < PARAM_BYTES; i++) begin
        par_q[i] <= '0;
      end
      parIdx_q <= '0;
      resIdx_q <= '0;
      oneByteRes_q <= 1'b0;
      ic_q <= IC_NORMAL;
      {nd_q, de_q, dd_q, cm_q, cmStop_q, stopSend_q} <= '0;
      idxCnt_q <= '0;
      byteCnt_q <= '0;
      wait_q <= '0;
      curCyl_q <= '0;
      headLoad_q <= 1'b0;
      seekReq_q <= 1'b0;
      busy_q <= '0;
      standby_q <= 1'b0;
      otherCmd_q <= 1'b0;
      lastFmt_q <= 1'b0;
      perp_q <= '0;
      resValid_q <= 1'b0;
      resByte_q <= '0;
      cmdReady_q <= 1'b1;
      dumpCount_q <= '0;
    end else begin
      state_q <= state_d;
      cmd_q <= cmd_d;
      par_q <= par_d;
      parIdx_q <= parIdx_d;
      resIdx_q <= resIdx_d;
      oneByteRes_q <= oneByteRes_d;
      ic_q <= ic_d;
      {nd_q, de_q, dd_q, cm_q, cmStop_q, stopSend_q} <=
        {nd_d, de_d, dd_d, cm_d, cmStop_d, stopSend_d};
      idxCnt_q <= idxCnt_d;
      byteCnt_q <= byteCnt_d;
      wait_q <= wait_d;
      curCyl_q <= curCyl_d;
      headLoad_q <= headLoad_d;
      seekReq_q <= seekReq_d;
      busy_q <= busy_d;
      standby_q <= standby_d;
      otherCmd_q <= otherCmd_d;
      lastFmt_q <= lastFmt_d;
      perp_q <= perp_d;
      resValid_q <= resValid_d;
      resByte_q <= resByte_d;
      cmdReady_q <= cmdReady_d;
      dumpCount_q <= dumpCount_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs and data FIFO
  // ---------------------------------------------------------------
  assign cmdReady = cmdReady_q;
  assign resValid = resValid_q;
  assign resByte = resByte_q;
  assign seekReq = seekReq_q;
  assign seekCyl = par_q[P_CYL];
  assign headLoad = headLoad_q;
  assign driveBusy = busy_q;
  assign standby = standby_q;
  assign otherCmd = otherCmd_q;
  assign perpMode = perp_q;
  // Shared count byte follows the kind of the latest format or transfer command
  assign dumpCount = dumpCount_q;

  drs_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .inValid(fifoInValid),
    .inData(diskByte),
    .inReady(fifoInReady),
    .outValid(dataValid),
    .outReady(dataReady),
    .outData(dataByte)
  );
endmodule // drs_sequencer

// file: src/drs_pkg.sv
// Shared constants and types for the disk read data sequencer
package drs_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_TIME_NS = 1000000;
  localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // Command layout
  // ---------------------------------------------------------------
  localparam int PARAM_BYTES = 8;
  localparam int RESULT_BYTES = 7;
  localparam logic [4:0] OP_READ = 5'h06;
  localparam logic [4:0] OP_READ_DEL = 5'h0c;
  localparam logic [4:0] OP_WRITE = 5'h05;
  localparam logic [4:0] OP_WRITE_DEL = 5'h09;
  localparam logic [4:0] OP_VERIFY = 5'h16;
  localparam logic [7:0] CMD_PERP = 8'h12;
  localparam logic [4:0] OP_FORMAT = 5'h0d;
  localparam int MT_BIT = 7;
  localparam int SK_BIT = 5;
  localparam int PERP_OW_BIT = 7;
  // Parameter byte slots after the first command byte
  localparam int P_SEL = 0;
  localparam int P_CYL = 1;
  localparam int P_HEAD = 2;
  localparam int P_SEC = 3;
  localparam int P_SIZE = 4;
  localparam int P_EOT = 5;
  localparam int P_DTL = 7;

  // ---------------------------------------------------------------
  // Status fields
  // ---------------------------------------------------------------
  localparam logic [7:0] INVALID_ST0 = 8'h80;
  localparam logic [1:0] IC_NORMAL = 2'h0;
  localparam logic [1:0] IC_ABNORMAL = 2'h1;
  localparam int ST1_ND_BIT = 2;
  localparam int ST1_DE_BIT = 5;
  localparam int ST2_CM_BIT = 6;
  localparam int ST2_DD_BIT = 5;
  localparam logic [7:0] FIRST_SECTOR = 8'h01;
  localparam logic [14:0] BASE_SECTOR_BYTES = 15'h0080;
  localparam int FIFO_DEPTH = 8;

  typedef struct packed {
    logic [7:0] cyl;
    logic [7:0] head;
    logic [7:0] sec;
    logic [7:0] size;
  } drs_id_t;

  typedef struct packed {
    logic overwrite;
    logic [3:0] driveEn;
    logic gapLen;
    logic writeGate;
  } drs_perp_t;
endpackage

// file: src/drs_fifo.sv
// Data FIFO with registered output stage
module drs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("drs_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [AW:0] count_q, count_d;
  logic outValid_q, outValid_d;
  logic [WIDTH-1:0] outData_q, outData_d;
  logic push, pop;

  // ---------------------------------------------------------------
  // Pointer and output stage
  // ---------------------------------------------------------------
  // Full is honest: the source sees ready drop and the offered byte is not stored
  assign inReady = (count_q != (AW+1)'(DEPTH));
  assign push = inValid && inReady;
  assign outValid = outValid_q;
  assign outData = outData_q;

  always_comb begin
    pop = (count_q != '0) && (!outValid_q || outReady);
    wrPtr_d = push ? wrPtr_q + 1'b1 : wrPtr_q;
    rdPtr_d = pop ? rdPtr_q + 1'b1 : rdPtr_q;
    count_d = count_q + (AW+1)'(push) - (AW+1)'(pop);
    outValid_d = pop ? 1'b1 : (outReady ? 1'b0 : outValid_q);
    outData_d = pop ? mem[rdPtr_q] : outData_q;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
      outValid_q <= 1'b0;
      outData_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      count_q <= count_d;
      outValid_q <= outValid_d;
      outData_q <= outData_d;
    end
  end

  // Storage needs no reset
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end
endmodule // drs_fifo

// file: dv/drs_checker.sv
// Port checker for the disk read data sequencer
module drs_checker import drs_pkg::*; (
  input wire logic clk,
  input wire logic nrst,
  input wire logic cmdValid,
  input wire logic cmdReady,
  input wire logic resValid,
  input wire logic [7:0] resByte,
  input wire logic resAck,
  input wire logic dataValid,
  input wire logic seekReq,
  input wire logic [3:0] driveBusy,
  input wire logic headLoad,
  input wire logic standby,
  input wire drs_perp_t perpMode
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // Properties
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  AST_INV: assert property ($rose(standby) |-> ##[0:1] (resValid && resByte == 8'h80))
    else $error("bad invalid code answer");
  AST_STBY: assert property ($fell(standby) && $past(nrst) |-> $past(cmdValid && cmdReady))
    else $error("standby left without command byte");
  AST_PERP: assert property ($changed(perpMode) && $past(nrst) |-> $past(cmdValid && cmdReady))
    else $error("perpendicular setting changed on its own");
  AST_SEEK: assert property (seekReq |-> !cmdReady)
    else $error("seek while still taking bytes");
  AST_BUSY: assert property (seekReq |-> ##[0:1] (driveBusy != 4'h0))
    else $error("drive busy missing in seek");
  AST_RES_HOLD: assert property (resValid && !resAck |=> resValid && $stable(resByte))
    else $error("result byte not held");
  AST_HEAD_DATA: assert property ($rose(dataValid) |-> headLoad)
    else $error("data without loaded head");
  AST_HEAD_RES: assert property (resValid && headLoad |=> headLoad)
    else $error("head unloaded in result phase");
endmodule // drs_checker

bind drs_sequencer drs_checker i_drs_checker (
  .clk(clk), .nrst(nrst), .cmdValid(cmdValid), .cmdReady(cmdReady), .resValid(resValid),
  .resByte(resByte), .resAck(resAck), .dataValid(dataValid), .seekReq(seekReq),
  .driveBusy(driveBusy), .headLoad(headLoad), .standby(standby), .perpMode(perpMode)
);

// file: dv/drs_disk_model.sv
// Behavioural drive: one spinning track of short sectors plus a seek answer
module drs_disk_model import drs_pkg::*; #(
  parameter int SPT = 4
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic seekReq,
  input wire logic [7:0] seekCyl,
  input wire logic [7:0] crcSec,
  input wire logic [7:0] secSize,
  output logic seekDone,
  output logic seekOk,
  output logic [7:0] seekFailCyl,
  output logic idxPulse,
  output logic idValid,
  output drs_id_t idField,
  output logic idCrcOk,
  output logic markValid,
  output logic markDeleted,
  output logic byteValid,
  output logic [7:0] diskByte,
  output logic sectorEnd,
  output logic dataCrcOk
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // Track timing
  // ----
  // Slot leaves room for a 256-byte sector; size code bit 0 picks 128 or 256
  localparam int SLOT = 264;
  logic [10:0] pos;
  logic [7:0] cyl;
  logic [8:0] off;
  logic [8:0] len;
  logic [7:0] sec;
  // Disk spins whatever the head does, so the track never waits
  always_ff @(posedge clk) begin
    pos <= (!nrst || pos == 11'(SPT * SLOT)) ? 11'h000 : pos + 11'h001;
    seekDone <= seekReq;
    cyl <= !nrst ? 8'h00 : (seekReq ? seekCyl : cyl);
  end
  // Field strobes decoded from the track position
  assign off = 9'(pos % SLOT);
  assign sec = 8'(pos / SLOT) + 8'h01;
  assign len = secSize[0] ? 9'h100 : 9'h080;
  assign idxPulse = (pos == 11'(SPT * SLOT));
  assign idValid = (off == 9'h000) && !idxPulse;
  assign idField = {cyl, 8'h00, sec, secSize};
  assign idCrcOk = (sec != crcSec);
  assign markValid = (off == 9'h002);
  assign markDeleted = 1'b0;
  assign byteValid = (off >= 9'h004) && (off < len + 9'h004);
  assign diskByte = 8'(off - 9'h004); // Changes every cycle except at the index wrap, where off stays at 0
  assign sectorEnd = (off == len + 9'h004);
  assign dataCrcOk = 1'b1;
  // Cylinders from 50h up are out of reach and fail at a fixed cylinder
  assign seekOk = (seekCyl < 8'h50);
  assign seekFailCyl = 8'h07;
endmodule // drs_disk_model

// file: dv/drs_sequencer_test.sv
// Self-checking bench for the disk read data sequencer
module drs_sequencer_test import drs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, nrst, cmdValid, cmdReady, resValid, resAck, dataValid, seekReq, seekDone, seekOk;
  logic idxPulse, idValid, idCrcOk, markValid, markDel, byteValid, sectorEnd, dataCrcOk;
  logic headLoad, standby, tc;
  logic [7:0] cmdByte, resByte, dataByte, seekCyl, failCyl, diskByte, crcSec, dumpCount, v;
  logic [7:0] secSize;
  logic [3:0] driveBusy;
  drs_id_t idField;
  drs_perp_t perpMode;
  int errors = 0, checks_done = 0, nb = 0, cyc = 0, xl = 16;
  // ----
  // Design and drive
  // ----
  drs_sequencer #(.TICK_DIV(4)) i_drs_sequencer (
    .clk(clk), .nrst(nrst), .cmdValid(cmdValid), .cmdByte(cmdByte), .cmdReady(cmdReady),
    .resValid(resValid), .resByte(resByte), .resAck(resAck), .dataValid(dataValid),
    .dataByte(dataByte), .dataReady(1'b1), .terminal_count(tc), .impliedSeekEn(1'b1),
    .settleTicks(8'h01), .unloadTicks(8'hff), .seekReq(seekReq), .seekCyl(seekCyl),
    .seekDone(seekDone), .seekOk(seekOk), .seekFailCyl(failCyl),
    .index_pulse_input(idxPulse), .idValid(idValid), .idField(idField), .idCrcOk(idCrcOk),
    .markValid(markValid), .markDeleted(markDel), .diskByteValid(byteValid),
    .diskByte(diskByte), .sectorEnd(sectorEnd), .dataCrcOk(dataCrcOk), .headLoad(headLoad),
    .driveBusy(driveBusy), .standby(standby), .otherCmd(), .perpMode(perpMode),
    .dumpCount(dumpCount)
  );
  drs_disk_model i_drs_disk_model (
    .clk(clk), .nrst(nrst), .seekReq(seekReq), .seekCyl(seekCyl), .crcSec(crcSec),
    .secSize(secSize),
    .seekDone(seekDone), .seekOk(seekOk), .seekFailCyl(failCyl), .idxPulse(idxPulse),
    .idValid(idValid), .idField(idField), .idCrcOk(idCrcOk), .markValid(markValid),
    .markDeleted(markDel), .byteValid(byteValid), .diskByte(diskByte),
    .sectorEnd(sectorEnd), .dataCrcOk(dataCrcOk)
  );
  // ----
  // Tasks
  // ----
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bytes go out LSB first; valid stays up across a command to avoid a same-step toggle
  task automatic snd(input logic [71:0] c, input int n);
    for (int k = 0; k < n; k++) begin
      while (cmdReady !== 1'b1) @(posedge clk) #1;
      cmdValid = 1'b1;
      cmdByte = c[8*k +: 8];
      @(posedge clk) #1;
    end
    cmdValid = 1'b0;
    @(posedge clk) #1;
  endtask
  task automatic rd(output logic [7:0] b);
    while (resValid !== 1'b1) @(posedge clk) #1;
    b = resByte;
    resAck = 1'b1;
    @(posedge clk) #1;
    resAck = 1'b0;
    @(posedge clk) #1;
  endtask
  // Drains all seven result bytes, compares the first n
  task automatic res(input logic [55:0] e, input int n);
    logic [7:0] b;
    for (int k = 0; k < 7; k++) begin
      rd(b);
      if (k < n) chk(b, e[8*k +: 8]);
    end
  endtask
  task automatic end_sim();
    $display("errors=%0d checks=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ----
  // Clock, data sink, watchdog
  // ----
  always #5 clk = ~clk;
  // Each sector hands over bytes 0 up to the transfer length xl, then restarts
  always @(posedge clk) begin
    cyc++;
    if (dataValid === 1'b1) begin
      chk(dataByte, 8'(nb % xl));
      nb++;
    end
    if (cyc == 20000) begin
      errors++;
      end_sim();
    end
  end
  // ----
  // Scenarios
  // ----
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    cmdValid = 1'b0;
    cmdByte = 8'h00;
    resAck = 1'b0;
    crcSec = 8'h00;
    secSize = 8'h00;
    tc = 1'b0;
    repeat (4) @(posedge clk);
    #1 nrst = 1'b1;
    snd(72'h1f, 1);
    rd(v);
    chk(v, 8'h80);
    chk({7'h00, standby}, 8'h01);
    snd(72'ha512, 2);
    chk({1'b0, perpMode}, 8'h65);
    chk({7'h00, standby}, 8'h00);
    snd(72'h101b02000100010006, 9);
    res(56'h00010002000000, 7);
    chk(nb[7:0], 8'h20);
    chk(dumpCount, 8'h02);
    chk({7'h00, headLoad}, 8'h01);
    snd(72'h101b09000900010006, 9);
    res(56'h000440, 3);
    // Terminal count held high: nothing reaches the FIFO, the sector still ends
    nb = 0;
    tc = 1'b1;
    snd(72'h101b02000100010006, 9);
    res(56'h00020001000000, 7);
    tc = 1'b0;
    chk(nb[7:0], 8'h00);
    // Size code one with the length byte at ff: a full 256-byte sector
    xl = 256;
    secSize = 8'h01;
    snd(72'hff1b01010100010006, 9);
    res(56'h01010002000000, 7);
    chk(8'(nb / 16), 8'h10);
    secSize = 8'h00;
    crcSec = 8'h02;
    snd(72'h101b02000200010006, 9);
    res(56'h202040, 3);
    // Unreachable cylinder: the seek fails and the failing cylinder comes back
    snd(72'h101b02000100600006, 9);
    res(56'h07000040, 4);
    end_sim();
  end
endmodule // drs_sequencer_test
